// ### sim/serial_partner.sv
// Remote serial device that drives the receive line of the port.
`timescale 1ns/1ps
// ============================================================
// Serial partner
module serial_partner (
	input  wire logic clk_i,     // System clock
	output logic      rx_line_o, // Line into the port, idles high
	output logic      cts_n_o    // Clear-to-send, held asserted
);
	initial begin
		rx_line_o = 1'b1;
		cts_n_o   = 1'b0;
	end
	// Sends start, eight data bits LSB first, the given stop level, then one idle bit.
	task automatic send(input logic [7:0] data, input logic stop, input int per);
		logic [10:0] f;
		f = {1'b1, stop, data, 1'b0};
		for (int i = 0; i < 11; i++) begin
			rx_line_o <= f[i];
			repeat (per) @(posedge clk_i);
		end
	endtask
endmodule

// ### sim/uart_ir_bench.sv
// Self-checking bench for the infrared serial port.
`timescale 1ns/1ps
`include "uart_ir_consts.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
	$display("mismatch at %0t: %0h vs %0h", $time, (a), (b)); end end
// ============================================================
// Bench
module uart_ir_bench;
	logic        clk_sys_i, rstn_i, wr_i, rd_i, idle_mode_i, sleep_mode_i, p;
	logic [7:0]  addr_i;
	logic [15:0] wr_data_i, rd_data_o, d;
	logic        serial_in_i, clear_to_send_n_i, serial_out_o, serial_out_oe_o;
	logic        request_to_send_n_o, request_to_send_oe_o, tx_irq_o, rx_irq_o, wake_irq_o;
	logic [9:0]  v;
	int          failures, n_tests, cycles, wakes, per, k, rxirqs;
	uart_ir dut (.clk_sys_i, .rstn_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o,
		.idle_mode_i, .sleep_mode_i, .serial_in_i, .clear_to_send_n_i, .serial_out_o,
		.serial_out_oe_o, .request_to_send_n_o, .request_to_send_oe_o, .tx_irq_o,
		.rx_irq_o, .wake_irq_o);
	serial_partner peer (.clk_i(clk_sys_i), .rx_line_o(serial_in_i), .cts_n_o(clear_to_send_n_i));
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		cycles++;
		if (wake_irq_o === 1'b1)
			wakes++;
		if (rx_irq_o === 1'b1)
			rxirqs++;
		if (cycles == 30000) begin
			failures++;
			results();
		end
	end
	task automatic results();
		$display("failures=%0d n_tests=%0d", failures, n_tests);
		if (failures == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] x);
		@(posedge clk_sys_i);
		addr_i    <= a;
		wr_data_i <= x;
		wr_i      <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] x);
		@(posedge clk_sys_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		@(negedge clk_sys_i);
		x = rd_data_o;
	endtask
	// Measures the first low stretch of the transmit line, then samples ns bit centres.
	task automatic get_frame(input int ns);
		k   = 0;
		per = 0;
		v   = '0;
		while (serial_out_o !== 1'b0 && k < 3000) begin
			@(posedge clk_sys_i);
			k++;
		end
		while (serial_out_o === 1'b0 && per < 3000) begin
			@(posedge clk_sys_i);
			per++;
		end
		for (int i = 0; i < ns; i++) begin
			repeat (i == 0 ? per / 2 : per) @(posedge clk_sys_i);
			v[i] = serial_out_o;
		end
		`CHK(k < 3000, 1'b1);
	endtask
	task automatic hold_high(input int n);
		k = 0;
		repeat (n) begin
			@(posedge clk_sys_i);
			if (serial_out_o !== 1'b1)
				k++;
		end
	endtask
	initial begin
		rstn_i       = 1'b0;
		wr_i         = 1'b0;
		rd_i         = 1'b0;
		addr_i       = 8'h00;
		wr_data_i    = 16'h0000;
		idle_mode_i  = 1'b0;
		sleep_mode_i = 1'b0;
		repeat (4) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		rd(`OFS_MODE, d); `CHK(d, 16'h0000);
		rd(`OFS_STA, d); `CHK(d, 16'h0110);
		rd(8'h14, d); `CHK(d, 16'h0000);
		wr(`OFS_MODE, 16'hFFFF);
		rd(`OFS_MODE, d); `CHK(d, 16'hBBFF);
		wr(`OFS_MODE, 16'h8000);
		wr(`OFS_BRG, 16'h0001);
		wr(`OFS_STA, 16'h0400);
		for (int i = 0; i < 4; i++) begin
			wr(`OFS_MODE, {8'h80, 4'h0, i[0], i[1:0], 1'b0});
			wr(`OFS_TXREG, 16'h01A5);
			get_frame(10);
			`CHK(per, i[0] ? 8 : 32);
			`CHK(v, {1'b1, i != 1, 8'hA5});
			repeat (per * 2) @(posedge clk_sys_i);
		end
		// Divisor rewrite and a character queued while transmit is off.
		wr(`OFS_MODE, 16'h8000);
		wr(`OFS_BRG, 16'hFFFF);
		wr(`OFS_STA, 16'h0000);
		wr(`OFS_TXREG, 16'h00C3);
		wr(`OFS_BRG, 16'h0000);
		wr(`OFS_STA, 16'h0400);
		get_frame(10);
		`CHK(k < 8, 1'b1);
		`CHK(v, {2'b11, 8'hC3});
		wr(`OFS_STA, 16'h0C00);
		wr(`OFS_TXREG, 16'h0000);
		wr(`OFS_TXREG, 16'h0055);
		get_frame(0);
		`CHK(per, 208);
		get_frame(8);
		`CHK(v[7:0], 8'h55);
		rd(`OFS_STA, d); `CHK(d[11], 1'b0);
		peer.send(8'h3C, 1'b1, 16);
		peer.send(8'hC3, 1'b0, 16);
		rd(`OFS_STA, d); `CHK(d[2:0], 3'b001);
		`CHK(rxirqs, 2);
		rd(`OFS_RXREG, d); `CHK(d[7:0], 8'h3C);
		rd(`OFS_STA, d); `CHK(d[2:0], 3'b101);
		rd(`OFS_RXREG, d); `CHK(d[7:0], 8'hC3);
		repeat (5) peer.send(8'h11, 1'b1, 16);
		rd(`OFS_STA, d); `CHK(d[1], 1'b1);
		wr(`OFS_STA, 16'h0400);
		rd(`OFS_STA, d); `CHK(d[1:0], 2'b00);
		wr(`OFS_MODE, 16'h8040);
		wr(`OFS_TXREG, 16'h005A);
		hold_high(200);
		`CHK(k, 0);
		rd(`OFS_RXREG, d); `CHK(d[7:0], 8'h5A);
		wr(`OFS_MODE, 16'h8080);
		sleep_mode_i <= 1'b1;
		peer.send(8'h00, 1'b1, 16);
		`CHK(wakes, 1);
		sleep_mode_i <= 1'b0;
		rd(`OFS_MODE, d); `CHK(d[7], 1'b0);
		wr(`OFS_BRG, 16'h0003);
		wr(`OFS_MODE, 16'h8300);
		repeat (8) @(posedge clk_sys_i);
		k = 0;
		p = request_to_send_n_o;
		repeat (80) begin
			@(posedge clk_sys_i);
			if (request_to_send_n_o === 1'b1 && p === 1'b0)
				k++;
			p = request_to_send_n_o;
		end
		`CHK(k >= 19 && k <= 21, 1'b1);
		`CHK(request_to_send_oe_o, 1'b1);
		wr(`OFS_BRG, 16'h0000);
		wr(`OFS_MODE, 16'hA000);
		idle_mode_i <= 1'b1;
		wr(`OFS_TXREG, 16'h0077);
		hold_high(300);
		`CHK(k, 0);
		idle_mode_i <= 1'b0;
		get_frame(10);
		`CHK(v, {2'b11, 8'h77});
		results();
	end
endmodule

// ### sim/uart_ir_sva.sv
// Property checker for the infrared serial port, bound to its top module.
`timescale 1ns/1ps
`include "uart_ir_consts.svh"
// ============================================================
// Checker
module uart_ir_sva (
	input wire logic        clk_sys_i,            // System clock
	input wire logic        rstn_i,               // Reset, active low
	input wire logic [7:0]  addr_i,               // Register address
	input wire logic [15:0] wr_data_i,            // Write data
	input wire logic        wr_i,                 // Write strobe
	input wire logic        rd_i,                 // Read strobe
	input wire logic [15:0] rd_data_o,            // Read data
	input wire logic        serial_out_oe_o,      // Transmit pin enable
	input wire logic        request_to_send_oe_o, // Request pin enable
	input wire logic        tx_irq_o,             // Transmit interrupt
	input wire logic        wake_irq_o            // Wake interrupt
);
	logic [15:0] mode_r;
	logic [15:0] sta_r;
	logic [15:0] mode_d_r;
	logic [15:0] sta_d_r;
	wire         wr_mode = wr_i && addr_i == `OFS_MODE;
	wire         wr_sta  = wr_i && addr_i == `OFS_STA;
	wire         unmapped = addr_i != `OFS_MODE && addr_i != `OFS_STA && addr_i != `OFS_TXREG
		&& addr_i != `OFS_RXREG && addr_i != `OFS_BRG;
	// Shadows of what software wrote, plus one stage for the registered pin enables.
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode_r   <= 16'h0000;
			sta_r    <= 16'h0000;
			mode_d_r <= 16'h0000;
			sta_d_r  <= 16'h0000;
		end else begin
			if (wr_mode)
				mode_r <= wr_data_i;
			if (wr_sta)
				sta_r <= wr_data_i;
			mode_d_r <= mode_r;
			sta_d_r  <= sta_r;
		end
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);
	sequence brg_wr_rd;
		wr_i && addr_i == `OFS_BRG ##1 rd_i && addr_i == `OFS_BRG;
	endsequence
	a_read_data_idle: assert property (
		!rd_i |=> rd_data_o == 16'h0000)
		else $error("read data not zero outside a read");
	a_unmapped_zero: assert property (
		rd_i && unmapped |=> rd_data_o == 16'h0000)
		else $error("unmapped read not zero");
	a_divisor_readback: assert property (
		brg_wr_rd |=> rd_data_o == $past(wr_data_i, 2))
		else $error("divisor read back wrong");
	a_mode_readback: assert property (
		rd_i && addr_i == `OFS_MODE |=>
		(rd_data_o & 16'hFF5F) == ($past(mode_r) & `MODE_WMASK & 16'hFF5F))
		else $error("mode read back wrong");
	a_rts_oe_usage: assert property (
		request_to_send_oe_o == (mode_d_r[`M_EN] && mode_d_r[9:8] != 2'b00))
		else $error("request pin enable wrong");
	a_tx_oe_enable: assert property (
		serial_out_oe_o == (mode_d_r[`M_EN] && sta_d_r[`S_TXEN]))
		else $error("transmit pin enable wrong");
	a_txen_irq_delay: assert property (
		wr_sta && wr_data_i[`S_TXEN] && !sta_r[`S_TXEN] && mode_r[`M_EN] |-> ##3 tx_irq_o)
		else $error("no transmit interrupt after enable");
	a_wake_pulse: assert property (
		wake_irq_o |-> mode_r[`M_WAKE] ##1 !wake_irq_o)
		else $error("wake interrupt without wake bit or too long");
endmodule
bind uart_ir uart_ir_sva chk (.clk_sys_i, .rstn_i, .addr_i, .wr_data_i, .wr_i, .rd_i,
	.rd_data_o, .serial_out_oe_o, .request_to_send_oe_o, .tx_irq_o, .wake_irq_o);

// ### verilog/uart_ir.sv
// Full-duplex serial port with baud generator, FIFOs, auto-baud and infrared codec.
//
// Function
// - High-speed baud is clock over four times divisor plus one.
// - Standard mode divides by sixteen times divisor plus one; select bit picks path.
// - Writing the divisor clears the baud timer at once.
// - Setting transmit enable raises a transmit interrupt two cycles later.
// - A written byte moves to the idle shift register; shifting follows baud tick.
// - Enabling transmit with data loaded starts at once from a cleared timer.
// - Break request, dummy write, then sync byte; hardware clears the request.
// - Reading receive data advances FIFO; error flags follow the new head.
// - Infrared modes work only in standard sixteen-times mode.
// - Pin usage eleven with port enabled drives sixteen-times baud clock out; with high-speed select the code drives the four-times clock.
// - Infrared enable decodes receive pin and encodes transmit pin.
// - Port enable drives pins per pin usage; clear releases them, port idles.
// - Stop-in-idle set halts the port during Idle; clear keeps it running.
// - Request-to-send mode bit selects simplex or flow-control behaviour.
// - Pin usage selects the pins used; others stay with port latches.
// - Wake enable flags falling edge in Sleep, clears itself on next rise.
// - Loopback select bit enables or disables loopback mode.
// - Auto-baud measures the next 55h character and clears itself when done.
// - Receive polarity bit sets receive idle level to zero or one.
// - Parity field picks nine-bit or eight-bit parity; stop select picks stop count.
// - Break is start bit, twelve zeros, stop bit, then request clears.
// - Transmit interrupt select picks load, all-done or buffer-empty event.
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "uart_ir_consts.svh"
module uart_ir (
	input  wire logic        clk_sys_i,           // 100 MHz system clock
	input  wire logic        rstn_i,              // Asynchronous reset, active low
	input  wire logic [7:0]  addr_i,              // Register byte address
	input  wire logic [15:0] wr_data_i,           // Register write data
	input  wire logic        wr_i,                // Write strobe
	input  wire logic        rd_i,                // Read strobe
	output logic      [15:0] rd_data_o,           // Read data, cycle after strobe
	input  wire logic        idle_mode_i,         // Device is in Idle mode
	input  wire logic        sleep_mode_i,        // Device is in Sleep mode
	input  wire logic        serial_in_i,         // Receive pin
	input  wire logic        clear_to_send_n_i,   // Clear-to-send pin, active low
	output logic             serial_out_o,        // Transmit pin level
	output logic             serial_out_oe_o,     // Transmit pin driven by port
	output logic             request_to_send_n_o, // Request-to-send or baud clock out
	output logic             request_to_send_oe_o,// Request-to-send pin driven by port
	output logic             tx_irq_o,            // Transmit interrupt pulse
	output logic             rx_irq_o,            // Receive interrupt pulse
	output logic             wake_irq_o           // Wake-up interrupt pulse
);
	// ============================================================
	// Registers and configuration decode
	// State names taken from the package without importing it.
	localparam uart_ir_pkg::tx_state_t TX_IDLE  = uart_ir_pkg::TX_IDLE;
	localparam uart_ir_pkg::tx_state_t TX_START = uart_ir_pkg::TX_START;
	localparam uart_ir_pkg::tx_state_t TX_DATA  = uart_ir_pkg::TX_DATA;
	localparam uart_ir_pkg::tx_state_t TX_PAR   = uart_ir_pkg::TX_PAR;
	localparam uart_ir_pkg::tx_state_t TX_STOP  = uart_ir_pkg::TX_STOP;
	localparam uart_ir_pkg::rx_state_t RX_IDLE  = uart_ir_pkg::RX_IDLE;
	localparam uart_ir_pkg::rx_state_t RX_START = uart_ir_pkg::RX_START;
	localparam uart_ir_pkg::rx_state_t RX_DATA  = uart_ir_pkg::RX_DATA;
	localparam uart_ir_pkg::rx_state_t RX_PAR   = uart_ir_pkg::RX_PAR;
	localparam uart_ir_pkg::rx_state_t RX_STOP  = uart_ir_pkg::RX_STOP;
	logic [15:0] mode_r, sta_r, divisor_r, brg_cnt_r;
	logic        receive_overrun_flag_r;
	wire wr_mode = wr_i & (addr_i == `OFS_MODE);
	wire wr_sta  = wr_i & (addr_i == `OFS_STA);
	wire wr_tx   = wr_i & (addr_i == `OFS_TXREG);
	wire wr_brg  = wr_i & (addr_i == `OFS_BRG);
	wire rd_rx   = rd_i & (addr_i == `OFS_RXREG);
	wire       en     = mode_r[`M_EN];
	wire       high_speed_baud_select   = mode_r[`M_HIGH_SPEED_BAUD_SELECT];
	wire [1:0] uen    = mode_r[`M_UEN_HI:`M_UEN_LO];
	wire [1:0] pdsel  = mode_r[`M_PD_HI:`M_PD_LO];
	wire       nine   = (pdsel == 2'h3);
	wire       has_par = (pdsel == 2'h1) | (pdsel == 2'h2);
	wire       odd    = (pdsel == 2'h2);
	wire       ir_on  = mode_r[`M_INFRARED_ENABLE] & ~high_speed_baud_select;
	wire       txen   = sta_r[`S_TXEN];
	wire       run    = en & ~sleep_mode_i & ~(idle_mode_i & mode_r[`M_SIDL]);
	wire [3:0] tpb_m1 = high_speed_baud_select ? `TPB_HI_M1 : `TPB_STD_M1;
	wire [3:0] half   = {1'b0, tpb_m1[3:1]};

	function automatic logic par_bit(input logic [7:0] d, input logic is_odd);
		par_bit = (^d) ^ is_odd;
	endfunction

	// ============================================================
	// Pin synchronisers
	logic rx_s1_r, rx_s2_r, cts_s1_r, cts_s2_r, pin_prev_r;
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_s1_r    <= 1'b1;
			rx_s2_r    <= 1'b1;
			cts_s1_r   <= 1'b1;
			cts_s2_r   <= 1'b1;
			pin_prev_r <= 1'b1;
		end else begin
			rx_s1_r    <= serial_in_i;
			rx_s2_r    <= rx_s1_r;
			cts_s1_r   <= clear_to_send_n_i;
			cts_s2_r   <= cts_s1_r;
			pin_prev_r <= rx_s2_r;
		end
	end

	// ============================================================
	// Baud rate generator
	logic txen_d_r;
	logic [1:0] txen_pipe_r;
	wire txen_rise = txen & ~txen_d_r;
	wire tick      = run & (brg_cnt_r == divisor_r);
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i)
			brg_cnt_r <= 16'h0000;
		else if (wr_brg | txen_rise | tick)
			brg_cnt_r <= 16'h0000;
		else if (run)
			brg_cnt_r <= brg_cnt_r + 16'h0001;
	end

	// ============================================================
	// Transmit FIFO and shifter
	logic [8:0] tx_mem [0:3];
	logic [1:0] tx_wp_r, tx_rp_r;
	logic [2:0] tx_cnt_r;
	uart_ir_pkg::tx_state_t tx_state_r;
	logic [8:0] tx_data_r;
	logic [3:0] tx_sub_r, tx_bit_r;
	logic       tx_brk_r, tx_ir_r;
	wire cts_ok   = (uen != 2'h2) | ~cts_s2_r;
	wire tx_full  = (tx_cnt_r == `FIFO_DEPTH);
	wire tx_flush = ~en | (~txen & txen_d_r);
	wire tx_push  = wr_tx & ~tx_full & en;
	// Loading on a baud tick makes the start bit last exactly one full bit time.
	wire tx_load  = tick & txen & cts_ok & (tx_state_r == TX_IDLE) & (tx_cnt_r != 3'h0);
	wire tx_end   = tick & (tx_sub_r == tpb_m1);
	wire [3:0] tx_last = tx_brk_r ? `BRK_BITS_M1 : (nine ? 4'h8 : 4'h7);
	wire tx_done  = tx_end & (tx_state_r == TX_STOP) & (~mode_r[`M_STOP_COUNT_SELECT] | tx_bit_r[0]);
	wire tx_line  = (tx_state_r == TX_START) ? 1'b0 :
	                (tx_state_r == TX_DATA)  ? (~tx_brk_r & tx_data_r[tx_bit_r]) :
	                (tx_state_r == TX_PAR)   ? par_bit(tx_data_r[7:0], odd) : 1'b1;
	wire brk_done = tx_done & tx_brk_r;

	always_ff @(posedge clk_sys_i) begin
		if (tx_push)
			tx_mem[tx_wp_r] <= wr_data_i[8:0];
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_wp_r  <= 2'h0;
			tx_rp_r  <= 2'h0;
			tx_cnt_r <= 3'h0;
		end else if (tx_flush) begin
			tx_wp_r  <= 2'h0;
			tx_rp_r  <= 2'h0;
			tx_cnt_r <= 3'h0;
		end else begin
			tx_wp_r  <= tx_wp_r + {1'b0, tx_push};
			tx_rp_r  <= tx_rp_r + {1'b0, tx_load};
			tx_cnt_r <= tx_cnt_r + {2'h0, tx_push} - {2'h0, tx_load};
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_state_r <= TX_IDLE;
			tx_data_r  <= 9'h000;
			tx_sub_r   <= 4'h0;
			tx_bit_r   <= 4'h0;
			tx_brk_r   <= 1'b0;
		end else if (tx_flush) begin
			tx_state_r <= TX_IDLE;
			tx_sub_r   <= 4'h0;
			tx_brk_r   <= 1'b0;
		end else begin
			if (tx_state_r == TX_IDLE)
				tx_sub_r <= 4'h0;
			else if (tx_end)
				tx_sub_r <= 4'h0;
			else if (tick)
				tx_sub_r <= tx_sub_r + 4'h1;
			case (tx_state_r)
				TX_IDLE: if (tx_load) begin
					tx_state_r <= TX_START;
					tx_data_r  <= tx_mem[tx_rp_r];
					tx_brk_r   <= sta_r[`S_BRK];
				end
				TX_START: if (tx_end) begin
					tx_state_r <= TX_DATA;
					tx_bit_r   <= 4'h0;
				end
				TX_DATA: if (tx_end) begin
					tx_bit_r <= tx_bit_r + 4'h1;
					if (tx_bit_r == tx_last) begin
						tx_state_r <= (has_par & ~tx_brk_r) ? TX_PAR : TX_STOP;
						tx_bit_r   <= 4'h0;
					end
				end
				TX_PAR: if (tx_end) begin
					tx_state_r <= TX_STOP;
					tx_bit_r   <= 4'h0;
				end
				TX_STOP: if (tx_end) begin
					tx_bit_r <= tx_bit_r + 4'h1;
					if (tx_done) begin
						tx_state_r <= TX_IDLE;
						tx_brk_r   <= 1'b0;
					end
				end
				default: tx_state_r <= TX_IDLE;
			endcase
		end
	end

	// Infrared encoder sends a short high pulse for each zero bit.
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i)
			tx_ir_r <= 1'b0;
		else
			tx_ir_r <= ~tx_line & (tx_sub_r < `IR_PULSE);
	end

	// ============================================================
	// Receive path, infrared decoder and auto-baud
	logic [4:0]  ir_hold_r;
	logic        rx_prev_r, rx_parity_error_flag_r;
	uart_ir_pkg::rx_state_t rx_state_r;
	logic [8:0]  rx_sh_r;
	logic [3:0]  rx_sub_r, rx_bit_r;
	logic [10:0] rx_mem [0:3];
	logic [1:0]  rx_wp_r, rx_rp_r;
	logic [2:0]  rx_cnt_r, ab_falls_r;
	logic [23:0] ab_cnt_r;
	wire ir_pulse = ~(rx_s2_r ^ mode_r[`M_RECEIVE_POLARITY_BIT]);
	wire ir_dec   = (ir_hold_r == 5'h00);
	wire rx_in    = mode_r[`M_LOOPBACK_SELECT] ? tx_line :
	                ir_on ? ir_dec : (rx_s2_r ^ mode_r[`M_RECEIVE_POLARITY_BIT]);
	wire rx_fall  = rx_prev_r & ~rx_in;
	wire auto_baud_bit    = mode_r[`M_AUTO_BAUD_BIT];
	wire rx_samp  = tick & (rx_sub_r == half);
	wire rx_end   = tick & (rx_sub_r == tpb_m1);
	wire rx_full  = (rx_cnt_r == `FIFO_DEPTH);
	wire rx_keep  = ~(sta_r[`S_ADDEN] & nine & ~rx_sh_r[8]);
	wire rx_frame = run & rx_samp & (rx_state_r == RX_STOP) & rx_keep;
	wire rx_push  = rx_frame & ~rx_full;
	wire rx_ovf   = rx_frame & rx_full;
	wire receive_overrun_flag_clr = wr_sta & ~wr_data_i[`S_RECEIVE_OVERRUN_FLAG] & receive_overrun_flag_r;
	wire rx_flush = ~en | receive_overrun_flag_clr;
	wire rx_pop   = rd_rx & (rx_cnt_r != 3'h0) & ~rx_flush;
	wire ab_done  = run & auto_baud_bit & rx_fall & (ab_falls_r == `AB_FALLS_LAST);
	wire [23:0] ab_q   = high_speed_baud_select ? (ab_cnt_r >> 5) : (ab_cnt_r >> 7);
	wire [15:0] ab_val = ab_q[15:0] - 16'h0001;
	wire [10:0] rx_head = rx_mem[rx_rp_r];

	always_ff @(posedge clk_sys_i) begin
		if (rx_push)
			rx_mem[rx_wp_r] <= {rx_parity_error_flag_r, ~rx_in, rx_sh_r};
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_wp_r  <= 2'h0;
			rx_rp_r  <= 2'h0;
			rx_cnt_r <= 3'h0;
		end else if (rx_flush) begin
			rx_wp_r  <= 2'h0;
			rx_rp_r  <= 2'h0;
			rx_cnt_r <= 3'h0;
		end else begin
			rx_wp_r  <= rx_wp_r + {1'b0, rx_push};
			rx_rp_r  <= rx_rp_r + {1'b0, rx_pop};
			rx_cnt_r <= rx_cnt_r + {2'h0, rx_push} - {2'h0, rx_pop};
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ir_hold_r  <= 5'h00;
			rx_prev_r  <= 1'b1;
			ab_cnt_r   <= 24'h000000;
			ab_falls_r <= 3'h0;
		end else begin
			rx_prev_r <= rx_in;
			if (ir_pulse)
				ir_hold_r <= `IR_HOLD;
			else if (tick & ~ir_dec)
				ir_hold_r <= ir_hold_r - 5'h01;
			if (~auto_baud_bit | ab_done) begin
				ab_falls_r <= 3'h0;
			end else if (run & rx_fall) begin
				ab_falls_r <= ab_falls_r + 3'h1;
				if (ab_falls_r == 3'h0)
					ab_cnt_r <= 24'h000000;
			end else if (run & (ab_falls_r != 3'h0)) begin
				ab_cnt_r <= ab_cnt_r + 24'h000001;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_state_r <= RX_IDLE;
			rx_sh_r    <= 9'h000;
			rx_sub_r   <= 4'h0;
			rx_bit_r   <= 4'h0;
			rx_parity_error_flag_r  <= 1'b0;
		end else if (~run) begin
			if (~en)
				rx_state_r <= RX_IDLE;
		end else begin
			if (rx_end)
				rx_sub_r <= 4'h0;
			else if (tick)
				rx_sub_r <= rx_sub_r + 4'h1;
			case (rx_state_r)
				RX_IDLE: if (rx_fall & ~auto_baud_bit) begin
					rx_state_r <= RX_START;
					rx_sub_r   <= 4'h0;
					rx_parity_error_flag_r  <= 1'b0;
					rx_sh_r    <= 9'h000;
				end
				RX_START: begin
					if (rx_samp & rx_in)
						rx_state_r <= RX_IDLE;
					else if (rx_end) begin
						rx_state_r <= RX_DATA;
						rx_bit_r   <= 4'h0;
					end
				end
				RX_DATA: begin
					if (rx_samp)
						rx_sh_r[rx_bit_r] <= rx_in;
					if (rx_end) begin
						rx_bit_r <= rx_bit_r + 4'h1;
						if (rx_bit_r == (nine ? 4'h8 : 4'h7))
							rx_state_r <= has_par ? RX_PAR : RX_STOP;
					end
				end
				RX_PAR: begin
					if (rx_samp)
						rx_parity_error_flag_r <= rx_in ^ par_bit(rx_sh_r[7:0], odd);
					if (rx_end)
						rx_state_r <= RX_STOP;
				end
				RX_STOP: if (rx_samp)
					rx_state_r <= RX_IDLE;
				default: rx_state_r <= RX_IDLE;
			endcase
		end
	end

	// ============================================================
	// Software registers with hardware set and clear
	logic wake_arm_r;
	wire pin_fall = pin_prev_r & ~rx_s2_r;
	wire pin_rise = ~pin_prev_r & rx_s2_r;
	wire wake_ev  = sleep_mode_i & mode_r[`M_WAKE] & pin_fall;
	wire wake_clr = wake_arm_r & pin_rise;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode_r     <= `MODE_RESET;
			sta_r      <= 16'h0000;
			receive_overrun_flag_r     <= 1'b0;
			divisor_r  <= 16'h0000;
			wake_arm_r <= 1'b0;
		end else begin
			if (wr_mode)
				mode_r <= wr_data_i & `MODE_WMASK;
			if (ab_done)
				mode_r[`M_AUTO_BAUD_BIT] <= 1'b0;
			if (wake_clr)
				mode_r[`M_WAKE] <= 1'b0;
			wake_arm_r <= wake_clr ? 1'b0 : (wake_arm_r | wake_ev);
			if (wr_sta)
				sta_r <= wr_data_i & `STA_WMASK;
			if (brk_done)
				sta_r[`S_BRK] <= 1'b0;
			if (rx_ovf)
				receive_overrun_flag_r <= 1'b1;
			else if (receive_overrun_flag_clr)
				receive_overrun_flag_r <= 1'b0;
			if (wr_brg)
				divisor_r <= wr_data_i;
			else if (ab_done)
				divisor_r <= ab_val;
		end
	end

	// ============================================================
	// Interrupt events
	wire [1:0] txis = {sta_r[`S_TXIS1], sta_r[`S_TXIS0]};
	wire [1:0] rxis = sta_r[`S_RXIS_HI:`S_RXIS_LO];
	wire tx_ev = ((txis == 2'h0) & tx_load) |
	             ((txis == 2'h2) & tx_load & (tx_cnt_r == 3'h1)) |
	             ((txis == 2'h1) & tx_done & (tx_cnt_r == 3'h0));
	wire rx_ev = rx_push & (~rxis[1] | (rxis[0] ? (rx_cnt_r == 3'h3) : (rx_cnt_r == 3'h2)));

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			txen_d_r    <= 1'b0;
			txen_pipe_r <= 2'h0;
			tx_irq_o    <= 1'b0;
			rx_irq_o    <= 1'b0;
			wake_irq_o  <= 1'b0;
		end else begin
			txen_d_r    <= txen;
			txen_pipe_r <= {txen_pipe_r[0], txen_rise};
			tx_irq_o    <= txen_pipe_r[0] | tx_ev;
			rx_irq_o    <= rx_ev;
			wake_irq_o  <= wake_ev;
		end
	end

	// ============================================================
	// Pins and read data
	wire tx_busy  = (tx_state_r != TX_IDLE) | (tx_cnt_r != 3'h0);
	wire rts_n    = mode_r[`M_RTS_MODE_SELECT] ? ~tx_busy : rx_full;
	wire bclk     = (brg_cnt_r <= {1'b0, divisor_r[15:1]});
	wire tx_pin   = mode_r[`M_LOOPBACK_SELECT] ? 1'b1 :
	                (ir_on ? tx_ir_r : tx_line) ^ sta_r[`S_TXINV];
	wire ridle    = (rx_state_r == RX_IDLE);
	wire [15:0] sta_rd = {sta_r[15:11], txen, tx_full, ~tx_busy, sta_r[7:5], ridle,
	                      rx_head[10] & (rx_cnt_r != 3'h0), rx_head[9] & (rx_cnt_r != 3'h0),
	                      receive_overrun_flag_r, rx_cnt_r != 3'h0};
	wire [15:0] rd_mux = (addr_i == `OFS_MODE)  ? mode_r :
	                     (addr_i == `OFS_STA)   ? sta_rd :
	                     (addr_i == `OFS_RXREG) ? {7'h00, rx_head[8:0]} :
	                     (addr_i == `OFS_BRG)   ? divisor_r : 16'h0000;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rd_data_o            <= 16'h0000;
			serial_out_o         <= 1'b1;
			serial_out_oe_o      <= 1'b0;
			request_to_send_n_o  <= 1'b1;
			request_to_send_oe_o <= 1'b0;
		end else begin
			rd_data_o            <= rd_i ? rd_mux : 16'h0000;
			serial_out_o         <= tx_pin;
			serial_out_oe_o      <= en & txen;
			request_to_send_n_o  <= (uen == 2'h3) ? bclk : rts_n;
			request_to_send_oe_o <= en & (uen != 2'h0);
		end
	end
endmodule

// ### verilog/uart_ir_consts.svh
// Register offsets, field positions and timing counts of the infrared serial port.
`ifndef UART_IR_CONSTS_SVH
`define UART_IR_CONSTS_SVH
// ============================================================
// Register byte offsets
`define OFS_MODE       8'h00
`define OFS_STA        8'h04
`define OFS_TXREG      8'h08
`define OFS_RXREG      8'h0C
`define OFS_BRG        8'h10
// ============================================================
// Mode register fields and reset value
`define MODE_RESET     16'h0000
`define MODE_WMASK     16'hBBFF
`define M_EN           15
`define M_SIDL         13
`define M_INFRARED_ENABLE         12
`define M_RTS_MODE_SELECT        11
`define M_UEN_HI       9
`define M_UEN_LO       8
`define M_WAKE         7
`define M_LOOPBACK_SELECT       6
`define M_AUTO_BAUD_BIT        5
`define M_RECEIVE_POLARITY_BIT        4
`define M_HIGH_SPEED_BAUD_SELECT         3
`define M_PD_HI        2
`define M_PD_LO        1
`define M_STOP_COUNT_SELECT        0
// ============================================================
// Status and control register fields
`define STA_WMASK      16'hECE0
`define S_TXIS1        15
`define S_TXINV        14
`define S_TXIS0        13
`define S_BRK          11
`define S_TXEN         10
`define S_RXIS_HI      7
`define S_RXIS_LO      6
`define S_ADDEN        5
`define S_RECEIVE_OVERRUN_FLAG         1
// ============================================================
// Timing counts in baud ticks, bits and falling edges, and the FIFO depth
`define TPB_STD_M1     4'hF
`define TPB_HI_M1      4'h3
`define IR_PULSE       4'h3
`define IR_HOLD        5'h10
`define FIFO_DEPTH     3'h4
`define BRK_BITS_M1    4'hB
`define AB_FALLS_LAST  3'h4
`endif

// ### verilog/uart_ir_pkg.sv
// Types shared by the infrared serial port.
package uart_ir_pkg;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
endpackage
